// ### verilog/eprom_access_control.sv
// Notes on behaviour
// - clearing latch enable also clears program enable
// - latch clear: EPROM reads return array contents
// - latch set: EPROM read data is invalid
// - latch set: vectors from EPROM are invalid
// - stop entry returns EPROM to read state
// - erased byte reads zero; programming sets ones
// - latch holds sixteen bytes per programming pulse
// - decode EPROM, user vectors and EEPROM
// - options register survives every reset
// - factory option byte reloaded from array
// - program enable needs latch plus loaded byte
// - stop and resets clear latch enable
// - three one-hot bits encode read, ready, programming
//
// The Avalon-MM slave port was chosen for this implementation.
`include "nvm_map.svh"

module eprom_access_control (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [14:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        stop_entry,
  output logic             eprom_latch_enable,
  output logic             eprom_program_enable,
  output logic             eprom_read_valid,
  output logic             external_clock_output,
  output logic             eeprom_latch_enable,
  output logic             eeprom_erase_select,
  output logic             eeprom_pump_enable,
  output logic             eeprom_upper_protect,
  output logic             security_lock,
  output logic      [4:0]  factory_option_byte
);

  nvm_pkg::eprom_state_t state;

  logic         request;
  logic         ack;
  logic [1:0]   phase;
  logic         booting;
  logic [1:0]   boot_phase;
  logic         commit_write;
  logic         ctrl_write;
  logic         hit_ctrl;
  logic         hit_eeprom;
  logic         hit_eprom;
  logic [14:0]  eprom_offset;
  logic [14:0]  rd_index;
  logic [7:0]   array_byte;
  logic         latch_load;
  logic [7:0]   latch_byte;
  logic [127:0] group_data;
  logic [15:0]  group_mask;
  logic         latch_any;
  logic [10:0]  group_row;
  logic         go_program;
  logic         pgm_pulse;
  logic [7:0]   eeprom_mem [256] = '{default: `EEPROM_ERASED_BYTE};
  logic [7:0]   eeprom_q;
  logic [7:0]   eeprom_pending_addr;
  logic [7:0]   eeprom_pending_data;
  logic         eeprom_loaded;
  logic         eeprom_fire;
  logic         eeprom_allowed;
  logic [7:0]   ctrl_value;
  logic [7:0]   options;

  // ---------------------------------------------------------------- decode
  assign hit_ctrl     = (address == `NVM_CONTROL_INDEX);
  assign hit_eeprom   = (address >= `EEPROM_FIRST_INDEX) &&
                        (address <= `EEPROM_LAST_INDEX);
  assign hit_eprom    = (address >= `EPROM_FIRST_INDEX) &&
                        (address <= `EPROM_LAST_INDEX);
  assign eprom_offset = address - `EPROM_FIRST_INDEX;

  // ---------------------------------------------------------- bus handshake
  // every access after the option fetch waits two cycles so array and EEPROM reads come from flops
  assign request     = read | write;
  assign waitrequest = request & ~ack;
  assign commit_write = write & ack;
  assign ctrl_write   = commit_write & hit_ctrl & byteenable[0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      ack   <= 1'b0;
    end else if (ack) begin
      phase <= 2'h0;
      ack   <= 1'b0;
    end else if (request && !booting) begin
      if (phase == `ACCESS_LAST_PHASE) begin
        ack <= 1'b1;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  // ------------------------------------------------ factory option reload
  // the byte lives in EPROM cells, so it is fetched again after each reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      booting             <= 1'b1;
      boot_phase          <= 2'h0;
      factory_option_byte <= 5'h00;
    end else if (booting) begin
      if (boot_phase == `FACTORY_LOAD_LAST_PHASE) begin
        factory_option_byte <= array_byte[4:0];
        booting             <= 1'b0;
      end else begin
        boot_phase <= boot_phase + 2'h1;
      end
    end
  end

  assign rd_index = booting ? (`FACTORY_OPTION_INDEX - `EPROM_FIRST_INDEX) : eprom_offset;

  // ------------------------------------------------------- EPROM state
  assign go_program = ctrl_write && !stop_entry && state == nvm_pkg::st_ready &&
                      writedata[`CTRL_EPROM_LATCH_BIT] &&
                      writedata[`CTRL_EPROM_PGM_BIT] && latch_any;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= nvm_pkg::st_read;
    end else if (stop_entry) begin
      state <= nvm_pkg::st_read;
    end else if (ctrl_write) begin
      case (state)
        nvm_pkg::st_read: begin
          // program enable cannot rise together with the latch: nothing loaded yet
          if (writedata[`CTRL_EPROM_LATCH_BIT]) begin
            state <= nvm_pkg::st_ready;
          end
        end
        nvm_pkg::st_ready: begin
          if (!writedata[`CTRL_EPROM_LATCH_BIT]) begin
            state <= nvm_pkg::st_read;
          end else if (go_program) begin
            state <= nvm_pkg::st_program;
          end
        end
        nvm_pkg::st_program: begin
          // writing zero to program enable alone has no effect
          if (!writedata[`CTRL_EPROM_LATCH_BIT]) begin
            state <= nvm_pkg::st_read;
          end
        end
        default: begin
          state <= nvm_pkg::st_read;
        end
      endcase
    end
  end

  assign eprom_latch_enable   = state[1] | state[2];
  assign eprom_program_enable = state[2];
  // vectors and loads from EPROM are only trustworthy in the read state
  assign eprom_read_valid     = state[0];

  // one programming pulse on entry; the supply switching and timing are external
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pgm_pulse <= 1'b0;
    end else begin
      pgm_pulse <= go_program;
    end
  end

  // ------------------------------------------------ programming latch load
  assign latch_load = commit_write && hit_eprom && byteenable[0] &&
                      state == nvm_pkg::st_ready;

  // bytes of one group differ only in the low four bits; the latest row wins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      group_row <= 11'h000;
    end else if (latch_load) begin
      group_row <= eprom_offset[14:4];
    end
  end

  eprom_program_latch u_latch (
    .clock      (clock),
    .rst_n      (rst_n),
    .clear      (state[0]),
    .load       (latch_load),
    .load_slot  (eprom_offset[3:0]),
    .load_byte  (writedata[7:0]),
    .read_slot  (eprom_offset[3:0]),
    .read_byte  (latch_byte),
    .group_data (group_data),
    .group_mask (group_mask),
    .any_loaded (latch_any)
  );

  eprom_array u_array (
    .clock     (clock),
    .rd_index  (rd_index),
    .rd_byte   (array_byte),
    .pgm_pulse (pgm_pulse),
    .pgm_group (group_row),
    .pgm_data  (group_data),
    .pgm_mask  (group_mask)
  );

  // ------------------------------------------------ EEPROM control bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_latch_enable   <= `CTRL_RESET;
      eeprom_erase_select   <= `CTRL_RESET;
      eeprom_pump_enable    <= `CTRL_RESET;
      external_clock_output <= `CTRL_RESET;
    end else begin
      if (stop_entry || (ctrl_write && !writedata[`CTRL_EE_LATCH_BIT])) begin
        eeprom_latch_enable <= 1'b0;
        eeprom_erase_select <= 1'b0;
        eeprom_pump_enable  <= 1'b0;
      end else if (ctrl_write) begin
        eeprom_latch_enable <= 1'b1;
        // erase select is frozen once an address has been taken
        if (!eeprom_loaded) begin
          eeprom_erase_select <= writedata[`CTRL_EE_ERASE_BIT];
        end
        // the pump only starts once data is selected, and stops only with the latch
        if (eeprom_loaded && eeprom_latch_enable && writedata[`CTRL_EE_PUMP_BIT]) begin
          eeprom_pump_enable <= 1'b1;
        end
      end
      if (ctrl_write) begin
        external_clock_output <= writedata[`CTRL_EXTERNAL_CLOCK_OUTPUT_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_loaded       <= 1'b0;
      eeprom_pending_addr <= 8'h00;
      eeprom_pending_data <= 8'h00;
    end else if (!eeprom_latch_enable) begin
      eeprom_loaded <= 1'b0;
    end else if (commit_write && hit_eeprom && byteenable[0] && !eeprom_pump_enable) begin
      eeprom_loaded       <= 1'b1;
      eeprom_pending_addr <= address[7:0];
      eeprom_pending_data <= writedata[7:0];
    end
  end

  assign eeprom_fire    = ctrl_write && eeprom_loaded && eeprom_latch_enable &&
                          !eeprom_pump_enable && writedata[`CTRL_EE_PUMP_BIT] &&
                          writedata[`CTRL_EE_LATCH_BIT] && !stop_entry;
  // upper part refuses program and erase while the protect bit is clear
  assign eeprom_allowed = options[`OPT_UPPER_PROTECT_BIT] ||
                          ({7'h00, eeprom_pending_addr} <
                           (`EEPROM_PROTECT_FIRST - `EEPROM_FIRST_INDEX));

  // no reset on the cells: options and EEPROM data survive every reset
  always_ff @(posedge clock) begin
    if (eeprom_fire && eeprom_allowed) begin
      if (eeprom_erase_select) begin
        eeprom_mem[eeprom_pending_addr] <= `EEPROM_ERASED_BYTE;
      end else begin
        eeprom_mem[eeprom_pending_addr] <= eeprom_mem[eeprom_pending_addr] &
                                           eeprom_pending_data;
      end
    end
    eeprom_q <= eeprom_mem[address[7:0]];
  end

  assign options              = eeprom_mem[0];
  assign eeprom_upper_protect = options[`OPT_UPPER_PROTECT_BIT];
  assign security_lock        = options[`OPT_SECURITY_BIT];

  // ---------------------------------------------------------- read data
  assign ctrl_value = {2'b00, eprom_latch_enable, eprom_program_enable,
                       external_clock_output, eeprom_erase_select,
                       eeprom_latch_enable, eeprom_pump_enable};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= `UNMAPPED_READ;
    end else if (read && !ack && !booting && phase == `ACCESS_LAST_PHASE) begin
      if (hit_ctrl) begin
        readdata <= {24'h00_0000, ctrl_value};
      end else if (hit_eeprom) begin
        readdata <= {24'h00_0000, eeprom_q};
      end else if (hit_eprom && state[0]) begin
        readdata <= {24'h00_0000, array_byte};
      end else if (hit_eprom) begin
        // latch contents show through instead of the array
        readdata <= {24'h00_0000, latch_byte};
      end else begin
        readdata <= `UNMAPPED_READ;
      end
    end
  end

endmodule

// ### verilog/nvm_map.svh
`ifndef NVM_MAP_SVH
`define NVM_MAP_SVH

// word indexes on the register bus; byte address is four times the index
`define NVM_CONTROL_INDEX        15'h0007
`define EEPROM_FIRST_INDEX       15'h0100
`define EEPROM_LAST_INDEX        15'h01ff
`define EEPROM_PROTECT_FIRST     15'h0120
`define EPROM_FIRST_INDEX        15'h0600
`define EPROM_LAST_INDEX         15'h7fff
`define EPROM_VECTOR_FIRST       15'h7ff2
`define FACTORY_OPTION_INDEX     15'h7fde

// array geometry
`define EPROM_GROUP_BYTES        16
`define EPROM_GROUP_COUNT        1952
`define EPROM_ERASED_BYTE        8'h00
`define EEPROM_ERASED_BYTE       8'hff

// control register fields and reset value
`define CTRL_EPROM_LATCH_BIT     5
`define CTRL_EPROM_PGM_BIT       4
`define CTRL_EXTERNAL_CLOCK_OUTPUT_BIT            3
`define CTRL_EE_ERASE_BIT        2
`define CTRL_EE_LATCH_BIT        1
`define CTRL_EE_PUMP_BIT         0
`define CTRL_RESET               1'b0

// options register fields
`define OPT_UPPER_PROTECT_BIT    1
`define OPT_SECURITY_BIT         0

// timing: cycles from request to answer, and after reset for the option fetch
`define ACCESS_LAST_PHASE        2'h1
`define FACTORY_LOAD_LAST_PHASE  2'h1
`define UNMAPPED_READ            32'h0000_0000

`endif

// ### verilog/nvm_pkg.sv
package nvm_pkg;

  typedef enum logic [2:0] {
    st_read    = 3'b001,
    st_ready   = 3'b010,
    st_program = 3'b100
  } eprom_state_t;

endpackage

// ### verilog/eprom_program_latch.sv
`include "nvm_map.svh"

module eprom_program_latch (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [3:0]   load_slot,
  input  wire logic [7:0]   load_byte,
  input  wire logic [3:0]   read_slot,
  output logic      [7:0]   read_byte,
  output logic      [127:0] group_data,
  output logic      [15:0]  group_mask,
  output logic              any_loaded
);

  genvar i;
  generate
    for (i = 0; i < `EPROM_GROUP_BYTES; i = i + 1) begin : slot
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          group_data[8*i +: 8] <= `EPROM_ERASED_BYTE;
          group_mask[i]        <= 1'b0;
        end else if (clear) begin
          group_data[8*i +: 8] <= `EPROM_ERASED_BYTE;
          group_mask[i]        <= 1'b0;
        end else if (load && load_slot == 4'(i)) begin
          group_data[8*i +: 8] <= load_byte;
          group_mask[i]        <= 1'b1;
        end
      end
    end
  endgenerate

  assign any_loaded = |group_mask;
  assign read_byte  = group_data[8*read_slot +: 8];

endmodule

// ### verilog/eprom_array.sv
`include "nvm_map.svh"

module eprom_array (
  input  wire logic         clock,
  input  wire logic [14:0]  rd_index,
  output logic      [7:0]   rd_byte,
  input  wire logic         pgm_pulse,
  input  wire logic [10:0]  pgm_group,
  input  wire logic [127:0] pgm_data,
  input  wire logic [15:0]  pgm_mask
);

  logic [7:0] bank_q [`EPROM_GROUP_BYTES];
  logic [3:0] bank_sel;

  always_ff @(posedge clock) begin
    bank_sel <= rd_index[3:0];
  end

  genvar i;
  generate
    for (i = 0; i < `EPROM_GROUP_BYTES; i = i + 1) begin : bank
      // erased image given at declaration so only the clocked process writes the cells
      logic [7:0] mem [`EPROM_GROUP_COUNT] = '{default: `EPROM_ERASED_BYTE};
      // cells only gain ones; a second pass on a byte accumulates
      always_ff @(posedge clock) begin
        if (pgm_pulse && pgm_mask[i] && pgm_group < 11'(`EPROM_GROUP_COUNT)) begin
          mem[pgm_group] <= mem[pgm_group] | pgm_data[8*i +: 8];
        end
        if (rd_index[14:4] < 11'(`EPROM_GROUP_COUNT)) begin
          bank_q[i] <= mem[rd_index[14:4]];
        end else begin
          bank_q[i] <= `EPROM_ERASED_BYTE;
        end
      end
    end
  endgenerate

  assign rd_byte = bank_q[bank_sel];

endmodule

// ### dv/eprom_access_control_properties.sv
`include "nvm_map.svh"

module eprom_access_control_properties (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [14:0] address,
  input wire logic        write,
  input wire logic        read,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic        waitrequest,
  input wire logic        stop_entry,
  input wire logic        eprom_latch_enable,
  input wire logic        eprom_program_enable,
  input wire logic        eprom_read_valid,
  input wire logic [4:0]  factory_option_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dflt @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic       ctrl_take;
  logic [1:0] since_reset;

  assign ctrl_take = write && !waitrequest && byteenable[0] &&
                     address == `NVM_CONTROL_INDEX;

  // the option fetch may move the byte during the first three edges only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) since_reset <= 2'h0;
    else if (since_reset != 2'h3) since_reset <= since_reset + 2'h1;
  end

  chk_latch_gates_pgm: assert property (!eprom_latch_enable |-> !eprom_program_enable)
    else $error("program enable high with latch enable low");
  chk_stop_to_read: assert property (
    stop_entry |=> !eprom_latch_enable && !eprom_program_enable)
    else $error("stop entry left the array out of read state");
  chk_valid_by_state: assert property (eprom_read_valid == !eprom_latch_enable)
    else $error("read valid does not follow latch enable");
  chk_pgm_rise_cause: assert property (
    $rose(eprom_program_enable) |-> $past(eprom_latch_enable) && $past(ctrl_take && writedata[4]))
    else $error("program enable rose without latch and control write");
  chk_pgm_no_clear: assert property ($fell(eprom_program_enable) |-> !eprom_latch_enable)
    else $error("program enable cleared while latch stayed set");
  chk_latch_rise_cause: assert property (
    $rose(eprom_latch_enable) |-> $past(ctrl_take && writedata[5] && !stop_entry))
    else $error("latch enable rose without control write");
  chk_two_waits: assert property (
    $rose(read || write) |-> waitrequest [*2] ##1 !waitrequest)
    else $error("access did not answer after two wait cycles");
  chk_factory_steady: assert property (
    since_reset == 2'h3 |=> $stable(factory_option_byte))
    else $error("factory option byte moved outside the reset fetch");
endmodule

bind eprom_access_control eprom_access_control_properties i_eprom_access_control_properties (
  .clock, .rst_n, .address, .write, .read, .writedata, .byteenable, .waitrequest,
  .stop_entry, .eprom_latch_enable, .eprom_program_enable, .eprom_read_valid,
  .factory_option_byte);

// ### dv/cpu_bus_master.sv
module cpu_bus_master (
  input  wire logic        clock,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output logic      [14:0] address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable
);
  timeunit 1ns;
  timeprecision 1ps;

  // programming code lives in ram, so no fetch reaches the array while latched
  initial begin
    address = 15'h0000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h1;
  end

  // request held until the edge that sees waitrequest low
  task automatic access(input logic [14:0] idx, input logic is_wr,
                        input logic [7:0] data, output logic [31:0] got);
    @(posedge clock);
    address <= idx;
    writedata <= {24'h00_0000, data};
    read <= !is_wr;
    write <= is_wr;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    got = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// ### dv/eprom_access_control_tb.sv
`include "nvm_map.svh"

module eprom_access_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rst_n;
  logic [14:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        stop_entry;
  logic        eprom_latch_enable;
  logic        eprom_program_enable;
  logic        eprom_read_valid;
  logic        external_clock_output;
  logic        eeprom_latch_enable;
  logic        eeprom_erase_select;
  logic        eeprom_pump_enable;
  logic        eeprom_upper_protect;
  logic        security_lock;
  logic [4:0]  factory_option_byte;
  logic [31:0] got;
  logic [7:0]  image [16];
  int          bad_count = 0;
  int          checks = 0;
  int          cycles = 0;

  eprom_access_control i_eprom_access_control (.clock, .rst_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .stop_entry, .eprom_latch_enable,
    .eprom_program_enable, .eprom_read_valid, .external_clock_output,
    .eeprom_latch_enable, .eeprom_erase_select, .eeprom_pump_enable,
    .eeprom_upper_protect, .security_lock, .factory_option_byte);
  cpu_bus_master i_cpu_bus_master (.clock, .waitrequest, .readdata, .address, .read,
    .write, .writedata, .byteenable);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic final_report();
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [14:0] idx, input logic [7:0] data);
    i_cpu_bus_master.access(idx, 1'b1, data, got);
  endtask

  task automatic rd_check(input string what, input logic [14:0] idx, input logic [31:0] exp);
    i_cpu_bus_master.access(idx, 1'b0, 8'h00, got);
    compare(what, exp, got);
  endtask

  // latch, program, valid; looked at once the edge's updates have landed
  task automatic state_check(input logic [2:0] exp);
    @(negedge clock);
    compare("state", 32'(exp),
            32'({eprom_latch_enable, eprom_program_enable, eprom_read_valid}));
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic stop_pulse();
    @(posedge clock);
    stop_entry <= 1'b1;
    @(posedge clock);
    stop_entry <= 1'b0;
  endtask

  task automatic t_after_reset(input logic [4:0] factory);
    state_check(3'b001);
    compare("factory", 32'(factory), 32'(factory_option_byte));
    compare("eebits", 32'h0000_0000, 32'({external_clock_output, eeprom_latch_enable,
            eeprom_erase_select, eeprom_pump_enable}));
    compare("options", 32'h0000_0003, 32'({eeprom_upper_protect, security_lock}));
    rd_check("ctrl", `NVM_CONTROL_INDEX, 32'h0000_0000);
    rd_check("optreg", `EEPROM_FIRST_INDEX, 32'h0000_00ff);
  endtask

  task automatic t_erased_map();
    rd_check("first", `EPROM_FIRST_INDEX, 32'h0000_0000);
    rd_check("last", `EPROM_LAST_INDEX, 32'h0000_0000);
    rd_check("vector", `EPROM_VECTOR_FIRST, 32'h0000_0000);
    rd_check("eeprom", `EEPROM_LAST_INDEX, 32'h0000_00ff);
    rd_check("gap", 15'h05ff, 32'h0000_0000);
  endtask

  task automatic t_closed_writes();
    wr(`EPROM_FIRST_INDEX, 8'h5a);
    rd_check("closed", `EPROM_FIRST_INDEX, 32'h0000_0000);
    wr(`NVM_CONTROL_INDEX, 8'h10);
    state_check(3'b001);
  endtask

  task automatic t_program_group();
    wr(`NVM_CONTROL_INDEX, 8'h20);
    state_check(3'b100);
    wr(`NVM_CONTROL_INDEX, 8'h30);
    state_check(3'b100);
    for (int i = 0; i < 16; i++) begin
      image[i] = 8'(i * 17 + 1);
      wr(15'h7fd0 + 15'(i), image[i]);
    end
    wr(`NVM_CONTROL_INDEX, 8'h30);
    state_check(3'b110);
    rd_check("ctrl", `NVM_CONTROL_INDEX, 32'h0000_0030);
    wr(`NVM_CONTROL_INDEX, 8'h20);
    state_check(3'b110);
    wr(`NVM_CONTROL_INDEX, 8'h00);
    state_check(3'b001);
    for (int i = 0; i < 16; i++) begin
      rd_check("group", 15'h7fd0 + 15'(i), 32'(image[i]));
    end
  endtask

  task automatic t_cumulative();
    wr(`NVM_CONTROL_INDEX, 8'h20);
    wr(15'h7fd0, 8'h80);
    wr(`NVM_CONTROL_INDEX, 8'h30);
    stop_pulse();
    state_check(3'b001);
    rd_check("or", 15'h7fd0, 32'(image[0] | 8'h80));
  endtask

  task automatic t_stop_in_ready();
    wr(`NVM_CONTROL_INDEX, 8'h20);
    wr(15'h7fd1, 8'hf0);
    stop_pulse();
    state_check(3'b001);
    // from read the latch may rise, but program enable needs a loaded byte first
    wr(`NVM_CONTROL_INDEX, 8'h30);
    state_check(3'b100);
    wr(`NVM_CONTROL_INDEX, 8'h00);
    rd_check("kept", 15'h7fd1, 32'(image[1]));
  endtask

  initial begin
    rst_n = 1'b0;
    stop_entry = 1'b0;
    do_reset();
    t_after_reset(5'h00);
    t_erased_map();
    t_closed_writes();
    t_program_group();
    t_cumulative();
    t_stop_in_ready();
    // reset in mid-programming setup must also drop the latch
    wr(`NVM_CONTROL_INDEX, 8'h2e);
    rd_check("ctrl", `NVM_CONTROL_INDEX, 32'h0000_002e);
    do_reset();
    t_after_reset(image[14][4:0]);
    rd_check("cells", `FACTORY_OPTION_INDEX, 32'(image[14]));
    final_report();
  end
endmodule
